// File: shared/sbc_pkg.sv
// Notes on behaviour
// R1: setup bit adds one extra setup clock
// R2: drive bit puts output latch on data
// R3: initiator drives latch only when I/O inactive
// R4: target drives latch only when I/O active
// R5: latch drive allowed even when not connected
// R6: software keeps drive bit clear during scripts
// R7: selection enable gates response to selections
// R8: selection response works in either role
// R9: software sets selection enable at initialisation
// R10: connected flag sets itself on connection
// R11: set by arbitration win or answered selection
// R12: also set by simple arbitration win
// R13: connected flag clear means not connected
// R14: software write forces connected or disconnected
// R15: bus reset bit drives reset until cleared
// R16: software times reset for 25 us minimum
// R17: forced even parity on send when generating
// R18: receive checking stays odd parity regardless
// R19: software keeps forced parity clear normally
// R20: parity generation ignores host parity input
// R21: parity check enable checks received bytes odd
// R22: two lowest bits are plain storage

package sbc_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int unsigned AW = 8;
    localparam logic [AW-1:0] OFS_CTL1  = 8'h00;
    localparam logic [AW-1:0] OFS_LATCH = 8'h04;
    localparam logic [AW-1:0] OFS_CTL0  = 8'h08;
    localparam logic [AW-1:0] OFS_STAT  = 8'h0c;

    localparam int unsigned B_EXTRA_SETUP = 7;
    localparam int unsigned B_DRIVE       = 6;
    localparam int unsigned B_SEL_EN      = 5;
    localparam int unsigned B_CONNECTED   = 4;
    localparam int unsigned B_BUS_RST     = 3;
    localparam int unsigned B_EVEN_PAR    = 2;

    localparam int unsigned B_TARGET  = 0;
    localparam int unsigned B_PAR_GEN = 2;
    localparam int unsigned B_PAR_CHK = 3;

    localparam int unsigned B_ST_PERR = 0;
    localparam int unsigned B_ST_RST  = 1;
    localparam int unsigned B_ST_IO   = 2;
    localparam int unsigned B_ST_SEL  = 3;
    localparam int unsigned B_ST_RX   = 8;

    localparam logic [7:0] CTL1_RST  = 8'h00;
    localparam logic [7:0] CTL0_RST  = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ      = 25;
    localparam int unsigned SETUP_CYCLES = 1;
    localparam int unsigned BUS_RST_MIN_US = 25;
    localparam int unsigned BUS_RST_MIN_CYC = BUS_RST_MIN_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [AW-1:0] awaddr;
        logic          awvalid;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          wvalid;
        logic          bready;
        logic [AW-1:0] araddr;
        logic          arvalid;
        logic          rready;
    } sbc_axil_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } sbc_axil_rsp_s;

    typedef struct packed {
        logic [7:0] db;
        logic       par;
        logic       io;
        logic       sel;
        logic       rst;
    } sbc_pin_in_s;

    typedef struct packed {
        logic [7:0] db;
        logic       db_oe;
        logic       par;
        logic       par_oe;
        logic       rst;
        logic       rst_oe;
    } sbc_pin_out_s;

    function automatic logic sbc_odd_par(input logic [7:0] b);
        return ~(^b);
    endfunction

    function automatic logic sbc_mapped(input logic [AW-1:0] a);
        return (a == OFS_CTL1) || (a == OFS_LATCH) || (a == OFS_CTL0) || (a == OFS_STAT);
    endfunction

endpackage

// File: core/sbc_setup_seq.sv
`timescale 1ns/1ps
`default_nettype none

module sbc_setup_seq
    import sbc_pkg::*;
(
    input  wire logic       i_ref_clk, // core clock
    input  wire logic       i_rst,     // sync reset, high
    input  wire logic       i_start,   // send one byte
    input  wire logic [7:0] i_byte,    // byte to send
    input  wire logic       i_extra,   // add setup clock
    output logic            o_busy,    // sequence running
    output logic            o_strobe,  // byte valid on bus
    output logic [7:0]      o_byte     // byte held for bus
);

    typedef enum logic [1:0] {IDLE, SETUP, EXTRA, STROBE} sbc_xfer_e;

    typedef struct packed {
        sbc_xfer_e  st;
        logic [3:0] cnt;
        logic [7:0] data;
    } sbc_seq_s;

    sbc_seq_s r;
    sbc_seq_s n;

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    always_comb begin
        n = r;
        unique case (r.st)
            IDLE: begin
                if (i_start) begin
                    n.st   = SETUP;
                    n.cnt  = 4'(SETUP_CYCLES);
                    n.data = i_byte;
                end
            end
            SETUP: begin
                n.cnt = r.cnt - 4'h1;
                if (r.cnt <= 4'h1) begin
                    n.st = i_extra ? EXTRA : STROBE; // see R1
                end
            end
            EXTRA:  n.st = STROBE;
            STROBE: n.st = IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_busy   = (r.st != IDLE);
    assign o_strobe = (r.st == STROBE);
    assign o_byte   = r.data;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence s_take;
        i_start && !o_busy;
    endsequence

    ext_setup_a: assert property (s_take ##1 i_extra |-> ##1 !o_strobe ##1 o_strobe) // see R1
        else $error("extra setup clock missing");
    no_ext_a: assert property (s_take ##1 !i_extra |-> ##1 o_strobe) // see R1
        else $error("setup clock added when not asked");
    strobe_one_a: assert property (o_strobe |=> !o_strobe)
        else $error("strobe longer than one clock");

endmodule // sbc_setup_seq

`default_nettype wire

// File: core/sbc_bus_control.sv
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module sbc_bus_control
    import sbc_pkg::*;
(
    input  wire logic          i_ref_clk,        // core clock, 25 MHz
    input  wire logic          i_rst,            // sync reset, high
    input  wire sbc_axil_req_s i_axi,            // register bus requests
    output sbc_axil_rsp_s      o_axi,            // register bus answers
    input  wire sbc_pin_in_s   i_pins,           // bus pin levels
    output sbc_pin_out_s       o_pins,           // bus pin drives
    input  wire logic          i_tx_start,       // send byte request
    input  wire logic [7:0]    i_tx_byte,        // byte to send
    input  wire logic          i_host_par,       // host parity bit
    output logic               o_tx_busy,        // send in progress
    output logic               o_tx_strobe,      // byte valid on bus
    input  wire logic          i_rx_strobe,      // sample received byte
    output logic [7:0]         o_rx_byte,        // last received byte
    output logic               o_rx_perr,        // parity error pulse
    input  wire logic          i_arb_won,        // full arbitration won
    input  wire logic          i_simple_arb_won, // simple arbitration won
    input  wire logic          i_sel_answered,   // selection answered
    input  wire logic          i_disconnect,     // left the bus
    output logic               o_sel_respond,    // may answer selection
    output logic               o_connected,      // connected flag
    output logic               o_par_chk_en      // parity check enable
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        sbc_pin_in_s   s1;
        sbc_pin_in_s   s2;
        logic [7:0]    ctl1;
        logic [7:0]    latch;
        logic [7:0]    ctl0;
        logic          perr;
        logic [7:0]    rx_byte;
        logic          rx_perr;
        logic          aw_got;
        logic          w_got;
        logic [AW-1:0] waddr;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          rvalid;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
    } sbc_state_s;

    sbc_state_s r;
    sbc_state_s n;

    logic       seq_busy;
    logic       seq_strobe;
    logic [7:0] seq_byte;
    logic       tgt;
    logic       dir_ok;
    logic       gen_en;
    logic       chk_en;
    logic       rx_bad;
    logic [7:0] bus_byte;

    // ----------------------------------------------------------------
    // decoded controls
    // ----------------------------------------------------------------
    assign tgt    = r.ctl0[B_TARGET];
    assign gen_en = r.ctl0[B_PAR_GEN];
    assign chk_en = r.ctl0[B_PAR_CHK];

    // initiator sends while i/o is low, target while it is high
    assign dir_ok = tgt ? r.s2.io : !r.s2.io; // see R3 see R4

    // checking is odd parity whatever the forced-even bit says
    assign rx_bad = r.s2.par != sbc_odd_par(r.s2.db); // see R18

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n = r;
        n.s1 = i_pins;
        n.s2 = r.s1;
        n.rx_perr = 1'b0;

        // write address and data arrive in either order
        if (i_axi.awvalid && o_axi.awready) begin
            n.aw_got = 1'b1;
            n.waddr  = i_axi.awaddr;
        end
        if (i_axi.wvalid && o_axi.wready) begin
            n.w_got = 1'b1;
            n.wdata = i_axi.wdata;
            n.wstrb = i_axi.wstrb;
        end
        if (r.bvalid && i_axi.bready) begin
            n.bvalid = 1'b0;
        end

        // leaving the bus drops the flag before any software force
        if (i_disconnect) begin
            n.ctl1[B_CONNECTED] = 1'b0; // see R13
        end

        if (r.aw_got && r.w_got) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = sbc_mapped(r.waddr) ? RESP_OKAY : RESP_SLVERR;
            if (r.wstrb[0]) begin
                case (r.waddr)
                    // whole byte stored; low two bits only hold data
                    OFS_CTL1:  n.ctl1 = r.wdata[7:0]; // see R14 see R22
                    OFS_LATCH: n.latch = r.wdata[7:0];
                    OFS_CTL0:  n.ctl0 = r.wdata[7:0];
                    OFS_STAT: begin
                        if (r.wdata[B_ST_PERR]) begin
                            n.perr = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end

        // a connection event beats a same-cycle software clear
        if (i_arb_won || i_sel_answered) begin
            n.ctl1[B_CONNECTED] = 1'b1; // see R10 see R11
        end
        if (i_simple_arb_won) begin
            n.ctl1[B_CONNECTED] = 1'b1; // see R12
        end

        // received bytes; error set wins over the clear above
        if (i_rx_strobe) begin
            n.rx_byte = r.s2.db;
            if (chk_en && rx_bad) begin // see R21
                n.perr    = 1'b1;
                n.rx_perr = 1'b1;
            end
        end

        if (r.rvalid && i_axi.rready) begin
            n.rvalid = 1'b0;
        end
        if (i_axi.arvalid && o_axi.arready) begin
            n.rvalid = 1'b1;
            n.rdata  = 32'h0;
            n.rresp  = sbc_mapped(i_axi.araddr) ? RESP_OKAY : RESP_SLVERR;
            case (i_axi.araddr)
                OFS_CTL1:  n.rdata[7:0] = r.ctl1;
                OFS_LATCH: n.rdata[7:0] = r.latch;
                OFS_CTL0:  n.rdata[7:0] = r.ctl0;
                OFS_STAT: begin
                    n.rdata[B_ST_PERR] = r.perr;
                    n.rdata[B_ST_RST]  = r.s2.rst;
                    n.rdata[B_ST_IO]   = r.s2.io;
                    n.rdata[B_ST_SEL]  = r.s2.sel;
                    n.rdata[B_ST_RX +: 8] = r.rx_byte;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            r       <= '0;
            r.ctl1  <= CTL1_RST;
            r.ctl0  <= CTL0_RST;
            r.latch <= LATCH_RST;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------
    // send sequencer
    // ----------------------------------------------------------------
    sbc_setup_seq u_seq (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_start   (i_tx_start),
        .i_byte    (i_tx_byte),
        .i_extra   (r.ctl1[B_EXTRA_SETUP]), // see R1
        .o_busy    (seq_busy),
        .o_strobe  (seq_strobe),
        .o_byte    (seq_byte)
    );

    // ----------------------------------------------------------------
    // bus drives
    // ----------------------------------------------------------------
    // manual drive overrides a running send; scripts must keep it off
    assign bus_byte = r.ctl1[B_DRIVE] ? r.latch : seq_byte; // see R2

    always_comb begin
        o_pins.db = bus_byte;
        // not gated by the connected flag, so usable before connecting
        o_pins.db_oe = (r.ctl1[B_DRIVE] || seq_busy) && dir_ok; // see R5
        if (gen_en) begin
            // forcing even parity makes every sent byte look bad
            o_pins.par = sbc_odd_par(bus_byte) ^ r.ctl1[B_EVEN_PAR]; // see R17 see R20
        end else begin
            o_pins.par = i_host_par;
        end
        o_pins.par_oe = o_pins.db_oe;
        // reset line is open drain: pull low, never drive high
        o_pins.rst    = 1'b0;
        o_pins.rst_oe = r.ctl1[B_BUS_RST]; // see R15
    end

    // ----------------------------------------------------------------
    // user side and bus answers
    // ----------------------------------------------------------------
    // either role may answer; role does not gate the response
    assign o_sel_respond = r.ctl1[B_SEL_EN] && r.s2.sel; // see R7 see R8
    assign o_connected   = r.ctl1[B_CONNECTED];
    assign o_par_chk_en  = chk_en;
    assign o_tx_busy     = seq_busy;
    assign o_tx_strobe   = seq_strobe;
    assign o_rx_byte     = r.rx_byte;
    assign o_rx_perr     = r.rx_perr;

    assign o_axi.awready = !r.aw_got && !r.bvalid;
    assign o_axi.wready  = !r.w_got && !r.bvalid;
    assign o_axi.bvalid  = r.bvalid;
    assign o_axi.bresp   = r.bresp;
    assign o_axi.arready = !r.rvalid;
    assign o_axi.rvalid  = r.rvalid;
    assign o_axi.rdata   = r.rdata;
    assign o_axi.rresp   = r.rresp;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    logic ctl1_wr;
    assign ctl1_wr = r.aw_got && r.w_got && r.wstrb[0] && (r.waddr == OFS_CTL1);

    sequence s_io_low;
        !r.s2.io;
    endsequence

    sequence s_io_high;
        r.s2.io;
    endsequence

    latch_drive_a: assert property (r.ctl1[B_DRIVE] && o_pins.db_oe |-> o_pins.db == r.latch) // see R2
        else $error("latch not on data lines");

    init_dir_a: assert property (!tgt && o_pins.db_oe |-> s_io_low) // see R3
        else $error("initiator drove with i/o active");

    tgt_dir_a: assert property (tgt && o_pins.db_oe |-> s_io_high) // see R4
        else $error("target drove with i/o inactive");

    any_time_a: assert property (r.ctl1[B_DRIVE] && dir_ok && !o_connected |-> o_pins.db_oe) // see R5
        else $error("drive blocked while unconnected");

    sel_gate_a: assert property ($rose(r.s2.sel) && !r.ctl1[B_SEL_EN] |-> !o_sel_respond) // see R7
        else $error("answered selection while disabled");

    sel_role_a: assert property (r.ctl1[B_SEL_EN] && r.s2.sel |-> o_sel_respond) // see R8
        else $error("selection response blocked by role");

    con_set_a: assert property (i_arb_won || i_sel_answered || i_simple_arb_won
                                |=> o_connected) // see R10
        else $error("connected flag not set");

    con_force_a: assert property (ctl1_wr && !i_arb_won && !i_sel_answered && !i_simple_arb_won
                                  |=> o_connected == $past(r.wdata[B_CONNECTED])) // see R14
        else $error("software force of connected lost");

    con_drop_a: assert property (i_disconnect && !ctl1_wr && !i_arb_won && !i_sel_answered
                                 && !i_simple_arb_won |=> !o_connected) // see R13
        else $error("connected flag stuck after disconnect");

    rst_hold_a: assert property (o_pins.rst_oe && !ctl1_wr |=> o_pins.rst_oe) // see R15
        else $error("bus reset released without write");

    rst_set_a: assert property (ctl1_wr && r.wdata[B_BUS_RST] |=> o_pins.rst_oe ##1 o_pins.rst_oe) // see R15
        else $error("bus reset not asserted");

    even_par_a: assert property (gen_en && r.ctl1[B_EVEN_PAR] |-> o_pins.par == ^o_pins.db) // see R17
        else $error("forced even parity not sent");

    host_par_a: assert property (!gen_en |-> o_pins.par == i_host_par) // see R20
        else $error("host parity not passed");

    gen_par_a: assert property (gen_en && !r.ctl1[B_EVEN_PAR] |-> o_pins.par == ~(^o_pins.db)) // see R20
        else $error("generated parity not odd");

    rx_check_a: assert property (i_rx_strobe && chk_en && rx_bad |=> o_rx_perr && r.perr) // see R21
        else $error("receive parity error missed");

    rx_odd_a: assert property (i_rx_strobe && r.s2.par == ~(^r.s2.db) |=> !o_rx_perr) // see R18
        else $error("good odd parity flagged");

    wr_resp_a: assert property (r.aw_got && r.w_got |=> o_axi.bvalid)
        else $error("write response missing");

    rd_resp_a: assert property (i_axi.arvalid && o_axi.arready |=> o_axi.rvalid)
        else $error("read response missing");

endmodule // sbc_bus_control

`default_nettype wire

// File: test/sbc_bus_peer.sv
`timescale 1ns/1ps
`default_nettype none

module sbc_bus_peer
    import sbc_pkg::*;
(
    input  wire logic         i_ref_clk, // core clock
    input  wire logic         i_io,      // i/o phase level
    input  wire logic         i_sel,     // selection by far side
    input  wire logic         i_drive,   // far side drives data
    input  wire logic [7:0]   i_byte,    // byte from far side
    input  wire logic         i_bad_par, // send wrong parity
    input  wire sbc_pin_out_s i_dut,     // block drives
    output sbc_pin_in_s       o_pins     // resolved bus levels
);
    logic [7:0] idle_r = 8'h5a;

    // released lines toggle so a stale byte never reads as valid
    always @(posedge i_ref_clk) begin
        idle_r <= ~idle_r;
    end

    always_comb begin
        o_pins.io  = i_io;
        o_pins.sel = i_sel;
        o_pins.rst = i_dut.rst_oe;
        o_pins.db  = i_dut.db_oe ? i_dut.db : (i_drive ? i_byte : idle_r);
        if (i_dut.par_oe) begin
            o_pins.par = i_dut.par;
        end else if (i_drive) begin
            o_pins.par = ~(^i_byte) ^ i_bad_par;
        end else begin
            o_pins.par = idle_r[0];
        end
    end
endmodule // sbc_bus_peer

`default_nettype wire

// File: test/sbc_bus_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module sbc_bus_control_tb_top;
    import sbc_pkg::*;

    logic          clk = 1'b0;
    logic          rst = 1'b1;
    sbc_axil_req_s ax = '0;
    sbc_axil_rsp_s rs;
    sbc_pin_in_s   pin_in;
    sbc_pin_out_s  pin_out;
    logic          tx_start = 1'b0, host_par = 1'b0, rx_stb = 1'b0;
    logic          arb = 1'b0, sarb = 1'b0, sel_ans = 1'b0, disc = 1'b0;
    logic          io = 1'b0, sel = 1'b0, pdrive = 1'b0, bad = 1'b0;
    logic [7:0]    tx_byte = 8'h00, pbyte = 8'h00, rx_byte, b, sd;
    logic          tx_busy, tx_stb, rx_perr, sel_resp, conn, chk_en, sp, soe;
    logic [1:0]    resp;
    logic [31:0]   rd, d;
    int            mismatches = 0, check_count = 0, i, lat;

    always #20 clk = ~clk;

    sbc_bus_control dut (.i_ref_clk(clk), .i_rst(rst), .i_axi(ax), .o_axi(rs),
        .i_pins(pin_in), .o_pins(pin_out), .i_tx_start(tx_start), .i_tx_byte(tx_byte),
        .i_host_par(host_par), .o_tx_busy(tx_busy), .o_tx_strobe(tx_stb),
        .i_rx_strobe(rx_stb), .o_rx_byte(rx_byte), .o_rx_perr(rx_perr),
        .i_arb_won(arb), .i_simple_arb_won(sarb), .i_sel_answered(sel_ans),
        .i_disconnect(disc), .o_sel_respond(sel_resp), .o_connected(conn),
        .o_par_chk_en(chk_en));

    sbc_bus_peer peer (.i_ref_clk(clk), .i_io(io), .i_sel(sel), .i_drive(pdrive),
        .i_byte(pbyte), .i_bad_par(bad), .i_dut(pin_out), .o_pins(pin_in));

    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic hang;
        chk(32'h0, 32'h1);
        test_done();
    endtask

    // ready and valid are looked at mid-cycle: they hold until the next edge
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        logic aw, w, bb;
        int   k;
        aw = 1'b1;
        w = 1'b1;
        bb = 1'b1;
        @(posedge clk);
        ax.awaddr <= a;
        ax.wdata <= v;
        ax.wstrb <= 4'hf;
        ax.awvalid <= 1'b1;
        ax.wvalid <= 1'b1;
        ax.bready <= 1'b1;
        for (k = 0; bb; k++) begin
            if (k == 50) hang();
            @(negedge clk);
            aw = aw & ~rs.awready;
            w = w & ~rs.wready;
            resp = rs.bresp;
            bb = bb & ~rs.bvalid;
            @(posedge clk);
            ax.awvalid <= aw;
            ax.wvalid <= w;
            ax.bready <= bb;
        end
    endtask

    task automatic axr(input logic [7:0] a);
        logic ar, rr;
        int   k;
        ar = 1'b1;
        rr = 1'b1;
        @(posedge clk);
        ax.araddr <= a;
        ax.arvalid <= 1'b1;
        ax.rready <= 1'b1;
        for (k = 0; rr; k++) begin
            if (k == 50) hang();
            @(negedge clk);
            ar = ar & ~rs.arready;
            rd = rs.rdata;
            resp = rs.rresp;
            rr = rr & ~rs.rvalid;
            @(posedge clk);
            ax.arvalid <= ar;
            ax.rready <= rr;
        end
    endtask

    task automatic send(input logic [7:0] v);
        @(posedge clk);
        tx_byte <= v;
        tx_start <= 1'b1;
        @(posedge clk);
        tx_start <= 1'b0;
        for (lat = 1; lat < 20; lat++) begin
            @(negedge clk);
            if (tx_stb === 1'b1) break;
            @(posedge clk);
        end
        if (lat == 20) hang();
        sp = pin_out.par;
        sd = pin_out.db;
        soe = pin_out.db_oe;
    endtask

    function automatic logic exp_par(input logic [7:0] v, input int m, input logic hp);
        if (m & 4) return (~^v) ^ ((m & 2) != 0);
        return hp;
    endfunction

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        #2000000;
        hang();
    end

    initial begin
        void'($urandom(29454));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        axr(OFS_CTL1);
        chk(rd, {24'h0, CTL1_RST});
        axr(8'h10);
        chk(resp, RESP_SLVERR);
        axw(8'h11, 32'hff);
        chk(resp, RESP_SLVERR);
        axr(OFS_CTL1);
        chk(rd, {24'h0, CTL1_RST});
        for (i = 0; i < 8; i++) begin
            d = $urandom & 32'hffff_ffa7;
            axw(OFS_CTL1, d);
            axr(OFS_CTL1);
            chk(rd, {24'h0, d[7:0]});
        end
        axw(OFS_CTL1, 32'h08);
        repeat (BUS_RST_MIN_CYC) @(posedge clk);
        @(negedge clk);
        chk(pin_out.rst_oe, 1);
        axw(OFS_CTL1, 32'h0);
        @(negedge clk);
        chk(pin_out.rst_oe, 0);
        axw(OFS_LATCH, 32'ha5);
        axw(OFS_CTL1, 32'h40);
        for (i = 0; i < 4; i++) begin
            axw(OFS_CTL0, (i >> 1) & 1);
            io <= i[0];
            repeat (4) @(posedge clk);
            @(negedge clk);
            chk(pin_out.db_oe, i[0] == i[1]);
            if (i[0] == i[1]) chk(pin_out.db, 8'ha5);
        end
        io <= 1'b0;
        sel <= 1'b1;
        for (i = 0; i < 4; i++) begin
            axw(OFS_CTL0, i & 1);
            axw(OFS_CTL1, (i & 2) << 4);
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk(sel_resp, i[1]);
        end
        sel <= 1'b0;
        for (i = 0; i < 3; i++) begin
            @(posedge clk);
            arb <= (i == 0);
            sarb <= (i == 1);
            sel_ans <= (i == 2);
            @(posedge clk);
            {arb, sarb, sel_ans} <= 3'h0;
            @(negedge clk);
            chk(conn, 1);
            @(posedge clk);
            disc <= 1'b1;
            @(posedge clk);
            disc <= 1'b0;
            @(negedge clk);
            chk(conn, 0);
        end
        axw(OFS_CTL1, 32'h10);
        axr(OFS_CTL1);
        chk({rd[7:0], conn}, 9'h21);
        for (i = 0; i < 8; i++) begin
            b = 8'($urandom);
            @(posedge clk);
            host_par <= 1'($urandom);
            axw(OFS_CTL0, i & 4);
            axw(OFS_CTL1, ((i & 1) << 7) | ((i & 2) << 1));
            send(b);
            chk(lat, 1 + SETUP_CYCLES + (i & 1));
            chk(tx_busy, 1'b1);
            chk({soe, sd}, {1'b1, b});
            chk(sp, exp_par(b, i, host_par));
        end
        pdrive <= 1'b1;
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            pbyte <= 8'($urandom);
            bad <= i[0];
            axw(OFS_CTL0, (i & 2) << 2);
            chk(chk_en, i[1]);
            axw(OFS_CTL1, i & 4);
            repeat (3) @(posedge clk);
            rx_stb <= 1'b1;
            @(posedge clk);
            rx_stb <= 1'b0;
            @(negedge clk);
            chk(rx_perr, i[0] & i[1]);
            chk(rx_byte, pbyte);
        end
        axw(OFS_CTL1, 32'h0);
        test_done();
    end
endmodule // sbc_bus_control_tb_top

`default_nettype wire
